// ===== rtl/ccg_clock_ctrl.sv
`timescale 1ns/10ps
module ccg_clock_ctrl
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  input wire ccg_pkg::ccg_sfr_req_t I_SFR,
  input wire ccg_pkg::ccg_ticks_t I_TICKS,
  input wire logic I_WAIT,
  input wire logic I_WAKE,
  input wire logic I_CSP_MODE,
  input wire logic I_EXT_CLK_MODE,
  input wire logic I_MAIN_OSC_FAIL,
  output logic [7:0] O_SFR_RDATA,
  output logic O_MAIN_OSC_EN,
  output logic O_MAIN_DRIVE_HIGH,
  output logic O_HS_OSC_EN,
  output logic O_LS_OSC_EN,
  output logic [7:0] O_HS_TRIM_A,
  output logic [7:0] O_HS_TRIM_B,
  output logic O_OSC_PIN_MODE,
  output logic O_OSC_OUT_PIN_O,
  output logic O_OSC_OUT_PIN_OE,
  output logic O_CPU_CLK_EN,
  output logic O_ONCHIP_CLK_EN,
  output logic [ccg_pkg::N_PERIPH-1:0] O_PERIPH_CLK_EN,
  output logic O_STOP_MODE
);

  // Whole block state in one record
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] detect;
    logic [7:0] hs_ctrl;
    logic [7:0] trim_a;
    logic [7:0] trim_b;
    ccg_pkg::ccg_pwr_t pwr;
    logic [3:0] cpu_cnt;
    logic [2:0] cur_exp;
    logic cur_src;
    logic [ccg_pkg::PER_CNT_W-1:0] per_cnt;
    logic [7:0] rdata;
  } ccg_state_t;

  ccg_state_t s_q; // Registered state
  ccg_state_t s_d; // Next state

  // Divider taps for the peripheral clocks: 1, 2, 4, 8, 32
  localparam logic [ccg_pkg::PER_CNT_W-1:0] PER_TAP [ccg_pkg::N_PERIPH] =
    '{5'h00, 5'h01, 5'h03, 5'h07, 5'h1F};

  logic wr_c0; // Write strobes for ctrl0, ctrl1, detect and hs_ctrl
  logic wr_c1;
  logic wr_det;
  logic wr_hs;
  logic main_stopped; // Main clock not running for the core
  logic ls_auto; // Low-speed forced on by stop detection
  logic onchip_tick; // Selected on-chip oscillator edge
  logic sys_tick; // Selected system clock edge
  logic cpu_tick; // System edge seen by the CPU divider
  logic cpu_wrap; // Last system edge of a CPU period
  logic per_run; // Peripheral clocks allowed
  logic [2:0] want_exp; // Division exponent asked by software
  logic [3:0] cnt_max; // Last count of the current period
  logic fall_back; // Main gone while the on-chip source is asked

  // Address decode of the byte bus
  assign wr_c0 = I_SFR.we && (I_SFR.addr == ccg_pkg::ADDR_CTRL0);
  assign wr_c1 = I_SFR.we && (I_SFR.addr == ccg_pkg::ADDR_CTRL1);
  assign wr_det = I_SFR.we && (I_SFR.addr == ccg_pkg::ADDR_DETECT);
  assign wr_hs = I_SFR.we && (I_SFR.addr == ccg_pkg::ADDR_HS_CTRL);

  // Stop detection enabled and main oscillator failed
  assign ls_auto = (s_q.detect[ccg_pkg::BIT_DET_HI:ccg_pkg::BIT_DET_LO]
                    == ccg_pkg::DET_ENABLED) && I_MAIN_OSC_FAIL;

  // Oscillator enables, all off in stop mode
  // External clock mode keeps the main path alive: the stop bit cannot halt it
  always_comb
  begin
    O_MAIN_OSC_EN = s_q.ctrl1[ccg_pkg::BIT_PIN_SEL]
                    && (!s_q.ctrl0[ccg_pkg::BIT_MAIN_STOP] || I_EXT_CLK_MODE)
                    && (s_q.pwr == ccg_pkg::CCG_RUN);
    O_HS_OSC_EN = s_q.hs_ctrl[ccg_pkg::BIT_HS_EN]
                  && (s_q.pwr == ccg_pkg::CCG_RUN);
    O_LS_OSC_EN = (!s_q.ctrl1[ccg_pkg::BIT_LS_STOP] || ls_auto)
                  && (s_q.pwr == ccg_pkg::CCG_RUN);
  end

  // Main clock counts as stopped when disabled or failed
  // Stop mode also disables it, so stop counts as stopped here too
  assign main_stopped = !O_MAIN_OSC_EN || I_MAIN_OSC_FAIL;

  // A dead main clock never ends its period, so a pending move to the
  // on-chip source cannot wait for a wrap; a stopped clock has no phase
  // left to shorten, so moving at once is safe
  assign fall_back = !s_q.cur_src && main_stopped
                     && s_q.detect[ccg_pkg::BIT_SRC_SEL];

  // Pin function and output pin level
  assign O_OSC_PIN_MODE = s_q.ctrl1[ccg_pkg::BIT_PIN_SEL];
  // Output pin only ever drives high; the enable alone decides
  assign O_OSC_OUT_PIN_O = 1'b1;
  // In port mode the pin is an input; oscillator drives it otherwise
  assign O_OSC_OUT_PIN_OE = s_q.ctrl1[ccg_pkg::BIT_PIN_SEL]
                            && ((s_q.pwr == ccg_pkg::CCG_STOP)
                                || s_q.ctrl0[ccg_pkg::BIT_MAIN_STOP]);
  assign O_MAIN_DRIVE_HIGH = s_q.ctrl1[ccg_pkg::BIT_DRIVE];
  assign O_HS_TRIM_A = s_q.trim_a;
  assign O_HS_TRIM_B = s_q.trim_b;
  assign O_STOP_MODE = (s_q.pwr == ccg_pkg::CCG_STOP);
  assign O_SFR_RDATA = s_q.rdata;

  // On-chip source pick; oscillators that are off give no edges
  // Limitation: a swap between the two on-chip oscillators is immediate
  assign onchip_tick = s_q.hs_ctrl[ccg_pkg::BIT_ONCHIP_SEL]
                       ? (I_TICKS.hs_tick && O_HS_OSC_EN)
                       : (I_TICKS.ls_tick && O_LS_OSC_EN);
  assign O_ONCHIP_CLK_EN = onchip_tick;

  // System edge follows the source latched at a CPU period boundary or on fall_back
  always_comb
  begin
    if (s_q.pwr == ccg_pkg::CCG_STOP)
    begin
      sys_tick = 1'b0;
    end
    else if (s_q.cur_src)
    begin
      sys_tick = onchip_tick;
    end
    else
    begin
      sys_tick = I_TICKS.main_tick && !main_stopped;
    end
  end

  // Requested exponent: override wins over the two-bit field
  always_comb
  begin
    if (s_q.ctrl0[ccg_pkg::BIT_DIV8])
    begin
      want_exp = ccg_pkg::EXP_DIV8;
    end
    else if (s_q.ctrl1[ccg_pkg::BIT_DIV_HI:ccg_pkg::BIT_DIV_LO]
             == ccg_pkg::DIV_FIELD_16)
    begin
      want_exp = ccg_pkg::EXP_DIV16;
    end
    else
    begin
      want_exp = {1'b0, s_q.ctrl1[ccg_pkg::BIT_DIV_HI:ccg_pkg::BIT_DIV_LO]};
    end
  end

  // CPU divider; the CPU clock halts in wait mode
  // Counter restarts at each wrap, so a ratio change cuts no period except on fall_back
  assign cnt_max = 4'((5'h01 << s_q.cur_exp) - 5'h01);
  assign cpu_tick = sys_tick && !I_WAIT;
  assign cpu_wrap = cpu_tick && (s_q.cpu_cnt == cnt_max);
  assign O_CPU_CLK_EN = cpu_wrap;

  // Peripheral clocks stop in wait only when gating is enabled
  // The counter keeps running in wait so the taps stay in phase on exit
  assign per_run = !(I_WAIT && s_q.ctrl0[ccg_pkg::BIT_WAIT_GATE]);

  // One strobe per peripheral divider tap
  genvar gi;
  generate
    for (gi = 0; gi < ccg_pkg::N_PERIPH; gi++)
    begin : g_per
      assign O_PERIPH_CLK_EN[gi] = sys_tick && per_run
                                   && ((s_q.per_cnt & PER_TAP[gi]) == PER_TAP[gi]);
    end
  endgenerate

  // Next-state logic for registers, power state and dividers
  always_comb
  begin
    s_d = s_q;
    // Control register 0; main stop only settable on on-chip source
    if (wr_c0)
    begin
      s_d.ctrl0 = (I_SFR.wdata & ccg_pkg::WMASK_CTRL0)
                  | (ccg_pkg::RST_CTRL0 & ~ccg_pkg::WMASK_CTRL0);
      if (I_SFR.wdata[ccg_pkg::BIT_MAIN_STOP]
          && !s_q.detect[ccg_pkg::BIT_SRC_SEL])
      begin
        s_d.ctrl0[ccg_pkg::BIT_MAIN_STOP] = s_q.ctrl0[ccg_pkg::BIT_MAIN_STOP];
      end
    end
    // Control register 1; protect mode locks two bits
    if (wr_c1)
    begin
      s_d.ctrl1 = (I_SFR.wdata & ccg_pkg::WMASK_CTRL1)
                  | (ccg_pkg::RST_CTRL1 & ~ccg_pkg::WMASK_CTRL1);
      if (I_CSP_MODE)
      begin
        s_d.ctrl1[ccg_pkg::BIT_ALL_STOP] = s_q.ctrl1[ccg_pkg::BIT_ALL_STOP];
        s_d.ctrl1[ccg_pkg::BIT_LS_STOP] = s_q.ctrl1[ccg_pkg::BIT_LS_STOP];
      end
      else if (I_SFR.wdata[ccg_pkg::BIT_ALL_STOP] && (s_q.pwr == ccg_pkg::CCG_RUN))
      begin
        s_d.pwr = ccg_pkg::CCG_STOP;
        // Leaving a main-clock mode forces the divide-by-8 override
        if (!s_q.detect[ccg_pkg::BIT_SRC_SEL])
        begin
          s_d.ctrl0[ccg_pkg::BIT_DIV8] = 1'b1;
        end
      end
    end
    // Detect register and source select
    if (wr_det)
    begin
      s_d.detect = (I_SFR.wdata & ccg_pkg::WMASK_DETECT)
                   | (ccg_pkg::RST_DETECT & ~ccg_pkg::WMASK_DETECT);
    end
    // Failure with detection on falls back to the on-chip source
    // Set wins over a write in the same cycle, so software cannot clear it while ls_auto holds
    if (ls_auto)
    begin
      s_d.detect[ccg_pkg::BIT_SRC_SEL] = 1'b1;
    end
    if (wr_hs)
    begin
      s_d.hs_ctrl = I_SFR.wdata & ccg_pkg::WMASK_HS_CTRL;
    end
    if (I_SFR.we && (I_SFR.addr == ccg_pkg::ADDR_TRIM_A))
    begin
      s_d.trim_a = I_SFR.wdata;
    end
    if (I_SFR.we && (I_SFR.addr == ccg_pkg::ADDR_TRIM_B))
    begin
      s_d.trim_b = I_SFR.wdata;
    end
    // Wake event leaves stop mode and clears the stop bit
    // The override set on entry stays until software clears it
    case (s_q.pwr)
      ccg_pkg::CCG_STOP:
      begin
        if (I_WAKE)
        begin
          s_d.pwr = ccg_pkg::CCG_RUN;
          s_d.ctrl1[ccg_pkg::BIT_ALL_STOP] = 1'b0;
        end
      end
      default:
      begin
      end
    endcase
    // New ratio and source only at a period end, so no short phase;
    // the fall-back to the on-chip source is the one exception
    if (cpu_wrap || fall_back)
    begin
      s_d.cpu_cnt = 4'h0;
      s_d.cur_exp = want_exp;
      s_d.cur_src = s_q.detect[ccg_pkg::BIT_SRC_SEL];
    end
    else if (cpu_tick)
    begin
      s_d.cpu_cnt = s_q.cpu_cnt + 4'h1;
    end
    if (sys_tick)
    begin
      s_d.per_cnt = s_q.per_cnt + 5'h01;
    end
    // Registered read data; unmapped addresses read zero
    // Data lags the address by one cycle, which keeps the read path short
    case (I_SFR.addr)
      ccg_pkg::ADDR_CTRL0: s_d.rdata = s_q.ctrl0;
      ccg_pkg::ADDR_CTRL1: s_d.rdata = s_q.ctrl1;
      ccg_pkg::ADDR_DETECT: s_d.rdata = s_q.detect;
      ccg_pkg::ADDR_HS_CTRL: s_d.rdata = s_q.hs_ctrl;
      ccg_pkg::ADDR_TRIM_A: s_d.rdata = s_q.trim_a;
      ccg_pkg::ADDR_TRIM_B: s_d.rdata = s_q.trim_b;
      default: s_d.rdata = 8'h00;
    endcase
  end

  // State register; reset leaves the low-speed source at divide-by-8
  // Clock enable low freezes every field, dividers included
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      s_q.ctrl0 <= ccg_pkg::RST_CTRL0;
      s_q.ctrl1 <= ccg_pkg::RST_CTRL1;
      s_q.detect <= ccg_pkg::RST_DETECT;
      s_q.hs_ctrl <= ccg_pkg::RST_HS_CTRL;
      s_q.trim_a <= ccg_pkg::RST_TRIM;
      s_q.trim_b <= ccg_pkg::RST_TRIM;
      s_q.pwr <= ccg_pkg::CCG_RUN;
      s_q.cpu_cnt <= 4'h0;
      s_q.cur_exp <= ccg_pkg::EXP_DIV8;
      s_q.cur_src <= 1'b1;
      s_q.per_cnt <= 5'h00;
      s_q.rdata <= 8'h00;
    end
    else if (I_CE)
    begin
      s_q <= s_d;
    end
  end
endmodule : ccg_clock_ctrl

// ===== rtl/ccg_pkg.sv
// How it works
// - Main oscillator stays off through and after reset.
// - Main oscillator starts: pin select, then stop-bit cleared.
// - Source-select bit low picks main clock.
// - Main stop bit settable only on on-chip source.
// - External input clock ignores the main stop bit.
// - All-clock-stop bit enters stop, halting every clock.
// - On-chip clock is high- or low-speed oscillator.
// - Reset runs CPU from low-speed oscillator divided by eight.
// - Detect bits 11b and main stop start low-speed.
// - High-speed oscillator off until its enable bit set.
// - Two writable trim registers tune high-speed oscillator.
// - CPU clock divides by 1,2,4,8,16; override forces eight.
// - Field 00,01,10,11 gives 1,2,4,16 division.
// - Stop entry from main clock sets divide-by-8 override.
// - Wait gate bit stops peripheral clock during wait.
// - Pin select bit: ports when 0, oscillator when 1.
// - Oscillator output pin driven high while main clock stopped.
// - Low-speed stop bit: on when 0, off when 1.
// - Protect mode ignores writes to stop and low-speed bits.
// - Peripheral clocks divide by 1,2,4,8,32; halted in stop, gated in wait when the gate bit is set.
package ccg_pkg;
  // Byte-wide special-function register addresses
  localparam logic [7:0] ADDR_CTRL0 = 8'h06;
  localparam logic [7:0] ADDR_CTRL1 = 8'h07;
  localparam logic [7:0] ADDR_DETECT = 8'h0C;
  localparam logic [7:0] ADDR_HS_CTRL = 8'h2B;
  localparam logic [7:0] ADDR_TRIM_A = 8'h2C;
  localparam logic [7:0] ADDR_TRIM_B = 8'h2D;
  // Reset values
  localparam logic [7:0] RST_CTRL0 = 8'h68;
  localparam logic [7:0] RST_CTRL1 = 8'h20;
  localparam logic [7:0] RST_DETECT = 8'h04;
  localparam logic [7:0] RST_HS_CTRL = 8'h00;
  localparam logic [7:0] RST_TRIM = 8'h00;
  // Writable bits; the rest read back their reset value
  localparam logic [7:0] WMASK_CTRL0 = 8'h64;
  localparam logic [7:0] WMASK_CTRL1 = 8'hF9;
  localparam logic [7:0] WMASK_DETECT = 8'h07;
  localparam logic [7:0] WMASK_HS_CTRL = 8'h03;
  // Bit positions, control register 0
  localparam int BIT_WAIT_GATE = 2;
  localparam int BIT_MAIN_STOP = 5;
  localparam int BIT_DIV8 = 6;
  // Bit positions, control register 1
  localparam int BIT_ALL_STOP = 0;
  localparam int BIT_PIN_SEL = 3;
  localparam int BIT_LS_STOP = 4;
  localparam int BIT_DRIVE = 5;
  localparam int BIT_DIV_LO = 6;
  localparam int BIT_DIV_HI = 7;
  // Bit positions, detect and high-speed control registers
  localparam int BIT_DET_LO = 0;
  localparam int BIT_DET_HI = 1;
  localparam int BIT_SRC_SEL = 2;
  localparam int BIT_HS_EN = 0;
  localparam int BIT_ONCHIP_SEL = 1;
  // Division exponents, field codes and sizes
  localparam logic [2:0] EXP_DIV8 = 3'h3;
  localparam logic [2:0] EXP_DIV16 = 3'h4;
  localparam logic [1:0] DIV_FIELD_16 = 2'h3;
  localparam logic [1:0] DET_ENABLED = 2'h3;
  localparam int N_PERIPH = 5;
  localparam int PER_CNT_W = 5;

  typedef enum logic {CCG_RUN, CCG_STOP} ccg_pwr_t;

  // One register access from the CPU side
  typedef struct packed {
    logic [7:0] addr;
    logic we;
    logic [7:0] wdata;
  } ccg_sfr_req_t;

  // Oscillator edges, one-cycle strobes in the I_CLK domain
  typedef struct packed {
    logic main_tick;
    logic hs_tick;
    logic ls_tick;
  } ccg_ticks_t;
endpackage : ccg_pkg

// ===== sim/ccg_clock_ctrl_asserts.sv
`timescale 1ns/10ps
module ccg_clock_ctrl_asserts
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  input wire ccg_pkg::ccg_sfr_req_t I_SFR,
  input wire logic I_WAKE,
  input wire logic I_CSP_MODE,
  input wire logic O_MAIN_OSC_EN,
  input wire logic O_HS_OSC_EN,
  input wire logic O_LS_OSC_EN,
  input wire logic O_OSC_PIN_MODE,
  input wire logic O_OSC_OUT_PIN_O,
  input wire logic O_OSC_OUT_PIN_OE,
  input wire logic O_CPU_CLK_EN,
  input wire logic [ccg_pkg::N_PERIPH-1:0] O_PERIPH_CLK_EN,
  input wire logic O_STOP_MODE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  // Write of the all-clock-stop bit
  logic wr_stop;
  assign wr_stop = I_CE && I_SFR.we && I_SFR.addr == ccg_pkg::ADDR_CTRL1 && I_SFR.wdata[0];

  a_reset_osc_state: assert property (!$past(I_NRST) |->
    !O_MAIN_OSC_EN && !O_HS_OSC_EN && O_LS_OSC_EN) else $error("oscillators wrong after reset");
  a_stop_entry_write: assert property (wr_stop && !I_CSP_MODE && !O_STOP_MODE |=> O_STOP_MODE)
    else $error("stop not entered");
  a_protect_keeps_run: assert property (wr_stop && I_CSP_MODE && !O_STOP_MODE |=> !O_STOP_MODE)
    else $error("stop entered in protect mode");
  a_wake_leaves_stop: assert property (O_STOP_MODE && I_WAKE && I_CE |=> !O_STOP_MODE)
    else $error("stop not left on wake");
  a_stop_halts_all: assert property (O_STOP_MODE |-> !O_CPU_CLK_EN && !O_MAIN_OSC_EN
    && !O_HS_OSC_EN && O_PERIPH_CLK_EN == '0) else $error("clock running in stop");
  a_port_pin_input: assert property (!O_OSC_PIN_MODE |-> !O_OSC_OUT_PIN_OE)
    else $error("output pin driven in port mode");
  a_stop_pin_high: assert property (O_OSC_PIN_MODE && O_STOP_MODE |->
    O_OSC_OUT_PIN_OE && O_OSC_OUT_PIN_O) else $error("output pin not high in stop");
  a_cpu_with_f1: assert property (O_CPU_CLK_EN |-> O_PERIPH_CLK_EN[0])
    else $error("cpu pulse off a system tick");
  c_stop_write: cover property (wr_stop && !I_CSP_MODE);
  c_wake: cover property (O_STOP_MODE && I_WAKE);
  c_cpu_pulse: cover property (O_CPU_CLK_EN);
endmodule : ccg_clock_ctrl_asserts

bind ccg_clock_ctrl ccg_clock_ctrl_asserts ccg_clock_ctrl_asserts_inst (.I_CLK, .I_NRST, .I_CE,
  .I_SFR, .I_WAKE, .I_CSP_MODE, .O_MAIN_OSC_EN, .O_HS_OSC_EN, .O_LS_OSC_EN, .O_OSC_PIN_MODE,
  .O_OSC_OUT_PIN_O, .O_OSC_OUT_PIN_OE, .O_CPU_CLK_EN, .O_PERIPH_CLK_EN, .O_STOP_MODE);

// ===== sim/ccg_clock_ctrl_test.sv
`timescale 1ns/10ps
module ccg_clock_ctrl_test;
  `define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
  logic clk, nrst, wait_m, wake, csp, fail, ext;
  logic main_en, drive, hs_en, ls_en, pin_mode, out_o, out_oe, cpu_en, onchip_en, stop;
  logic [7:0] rdata, trim_a, trim_b, v;
  logic [ccg_pkg::N_PERIPH:0] seen; // CPU pulse on top of the peripheral strobes
  logic [ccg_pkg::N_PERIPH-1:0] per_en;
  ccg_pkg::ccg_sfr_req_t sfr;
  ccg_pkg::ccg_ticks_t ticks;
  int n_mismatch, num_checks;

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ccg_clock_ctrl ccg_clock_ctrl_inst (.I_CLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_SFR(sfr),
    .I_TICKS(ticks), .I_WAIT(wait_m), .I_WAKE(wake), .I_CSP_MODE(csp), .I_EXT_CLK_MODE(ext),
    .I_MAIN_OSC_FAIL(fail), .O_SFR_RDATA(rdata), .O_MAIN_OSC_EN(main_en),
    .O_MAIN_DRIVE_HIGH(drive), .O_HS_OSC_EN(hs_en), .O_LS_OSC_EN(ls_en), .O_HS_TRIM_A(trim_a),
    .O_HS_TRIM_B(trim_b), .O_OSC_PIN_MODE(pin_mode), .O_OSC_OUT_PIN_O(out_o),
    .O_OSC_OUT_PIN_OE(out_oe), .O_CPU_CLK_EN(cpu_en), .O_ONCHIP_CLK_EN(onchip_en),
    .O_PERIPH_CLK_EN(per_en), .O_STOP_MODE(stop));
  ccg_osc_model ccg_osc_model_inst (.i_clk(clk), .i_nrst(nrst), .i_main_en(main_en),
    .i_hs_en(hs_en), .i_ls_en(ls_en), .i_ext(ext), .i_fail(fail), .o_ticks(ticks));

  // Write strobe stands one cycle; outputs are looked at once it has landed
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) sfr <= {a, 1'b1, d};
    @(posedge clk) sfr.we <= 1'b0;
    #1;
  endtask : wr
  // Read data is registered, so it is taken one edge after the address
  task rd(input logic [7:0] a);
    @(posedge clk) sfr <= {a, 1'b0, 8'h00};
    @(posedge clk);
    #1 v = rdata;
  endtask : rd
  // Bounded wait for the next CPU pulse
  task wpulse;
    for (int i = 0; i < 300; i++)
    begin
      @(posedge clk);
      #1;
      if (cpu_en === 1'b1) return;
    end
    n_mismatch++;
    give_verdict;
  endtask : wpulse
  // The first pulse after a change may close an old period, so measure the next one
  task per(input int e);
    int i;
    wpulse;
    for (i = 1; i < 300; i++)
    begin
      @(posedge clk);
      #1;
      if (cpu_en === 1'b1) break;
    end
    `CHK("cpu period", e, i)
  endtask : per
  // Gathers every strobe seen over a stretch of cycles
  task watch;
    seen = '0;
    repeat (20)
    begin
      @(posedge clk);
      #1 seen = seen | {cpu_en, per_en};
    end
  endtask : watch

  task t_reset;
    rd(ccg_pkg::ADDR_CTRL0); `CHK("ctrl0", ccg_pkg::RST_CTRL0, v)
    rd(ccg_pkg::ADDR_CTRL1); `CHK("ctrl1", ccg_pkg::RST_CTRL1, v)
    `CHK("main en", 1'b0, main_en)
    `CHK("hs en", 1'b0, hs_en)
    `CHK("drive", 1'b1, drive)
    per(16);
  endtask : t_reset
  // Slow on-chip source ticks every second cycle
  task t_div;
    int r[4] = '{2, 4, 8, 32};
    wr(ccg_pkg::ADDR_CTRL0, 8'h20);
    for (int k = 0; k < 4; k++)
    begin
      wr(ccg_pkg::ADDR_CTRL1, {k[1:0], 6'h00});
      per(r[k]);
    end
    wr(ccg_pkg::ADDR_CTRL0, 8'h60);
    per(16);
    rd(ccg_pkg::ADDR_CTRL0); `CHK("ctrl0 back", 8'h68, v)
  endtask : t_div
  task t_main;
    wr(ccg_pkg::ADDR_CTRL1, 8'h08); `CHK("pin mode", 1'b1, pin_mode)
    `CHK("main early", 1'b0, main_en)
    wr(ccg_pkg::ADDR_CTRL0, 8'h08); `CHK("main on", 1'b1, main_en)
    wr(ccg_pkg::ADDR_DETECT, 8'h00); per(1);
    wr(ccg_pkg::ADDR_CTRL0, 8'h28); `CHK("main kept", 1'b1, main_en)
    wr(ccg_pkg::ADDR_CTRL1, 8'h09); `CHK("stop", 1'b1, stop)
    `CHK("pin high", 1'b1, out_oe && out_o)
    rd(ccg_pkg::ADDR_CTRL0); `CHK("div8 set", 8'h48, v)
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    #1 `CHK("woken", 1'b0, stop)
    wr(ccg_pkg::ADDR_CTRL1, 8'h18); `CHK("ls off", 1'b0, ls_en)
    wr(ccg_pkg::ADDR_DETECT, 8'h03);
    @(posedge clk) fail <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK("ls auto", 1'b1, ls_en)
    rd(ccg_pkg::ADDR_DETECT); `CHK("src onchip", 1'b1, v[2])
    // The dead main clock must not hold the CPU: low-speed ticks, divide-by-8
    per(16);
    @(posedge clk) fail <= 1'b0;
  endtask : t_main
  task t_csp_pins;
    wr(ccg_pkg::ADDR_CTRL1, 8'h08); `CHK("ls on", 1'b1, ls_en)
    @(posedge clk) csp <= 1'b1;
    wr(ccg_pkg::ADDR_CTRL1, 8'h19); `CHK("no stop", 1'b0, stop)
    rd(ccg_pkg::ADDR_CTRL1); `CHK("ctrl1 csp", 8'h08, v)
    @(posedge clk) csp <= 1'b0;
    wr(ccg_pkg::ADDR_CTRL0, 8'h68); `CHK("main off", 1'b0, main_en)
    `CHK("pin high", 1'b1, out_oe)
    @(posedge clk) ext <= 1'b1;
    #1 `CHK("ext kept", 1'b1, main_en)
    @(posedge clk) ext <= 1'b0;
    wr(ccg_pkg::ADDR_CTRL1, 8'h00); `CHK("pin input", 1'b0, out_oe)
  endtask : t_csp_pins
  task t_hs;
    int cnt[ccg_pkg::N_PERIPH];
    int pexp[ccg_pkg::N_PERIPH] = '{32, 16, 8, 4, 1};
    wr(ccg_pkg::ADDR_HS_CTRL, 8'h03); `CHK("hs on", 1'b1, hs_en)
    per(8);
    `CHK("onchip", 1'b1, onchip_en)
    // Over any 32 system ticks each tap fires an exact number of times
    foreach (cnt[b])
      cnt[b] = 0;
    repeat (32)
    begin
      @(posedge clk);
      #1;
      foreach (cnt[b])
        cnt[b] += int'(per_en[b]);
    end
    foreach (cnt[b])
      `CHK("periph count", pexp[b], cnt[b])
    wr(ccg_pkg::ADDR_TRIM_A, 8'hA5); `CHK("trim a", 8'hA5, trim_a)
    wr(ccg_pkg::ADDR_TRIM_B, 8'h5A); `CHK("trim b", 8'h5A, trim_b)
    wr(8'h10, 8'hFF); rd(8'h10); `CHK("unmapped", 8'h00, v)
  endtask : t_hs
  // Wait with gating on silences everything; gating off lets f1 run
  task t_wait;
    wr(ccg_pkg::ADDR_CTRL0, 8'h64);
    @(posedge clk) wait_m <= 1'b1;
    watch; `CHK("gated", 6'h00, seen)
    wr(ccg_pkg::ADDR_CTRL0, 8'h60);
    watch; `CHK("f1 runs", 2'b01, {seen[5], seen[0]})
    @(posedge clk) wait_m <= 1'b0;
  endtask : t_wait

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Reset for four cycles, then the scenarios in turn
  initial
  begin
    nrst = 1'b0;
    sfr = '0;
    {wait_m, wake, csp, fail, ext} = 5'h00;
    n_mismatch = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_div;
    t_main;
    t_csp_pins;
    t_hs;
    t_wait;
    give_verdict;
  end
endmodule : ccg_clock_ctrl_test

// ===== sim/ccg_osc_model.sv
`timescale 1ns/10ps
module ccg_osc_model
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_main_en,
  input wire logic i_hs_en,
  input wire logic i_ls_en,
  input wire logic i_ext,
  input wire logic i_fail,
  output ccg_pkg::ccg_ticks_t o_ticks
);
  // Phase bit; the slow oscillator ticks on every other cycle
  logic ph_q;

  // Oscillator edges; a disabled source gives no ticks, except the main one while i_ext is set
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ph_q <= 1'b0;
      o_ticks <= '0;
    end
    else
    begin
      ph_q <= !ph_q;
      // An external source runs on whatever the stop bit says
      o_ticks.main_tick <= (i_main_en || i_ext) && !i_fail;
      o_ticks.hs_tick <= i_hs_en;
      o_ticks.ls_tick <= i_ls_en && ph_q;
    end
  end
endmodule : ccg_osc_model
